// file: rtl/csfs_regs.svh
// Timing counts and fixed values for the configuration stream output unit
`ifndef CSFS_REGS_SVH
`define CSFS_REGS_SVH

`define CSFS_CLK_MHZ          100
`define CSFS_SHIFT_HALF_NS    50
`define CSFS_SHIFT_HALF_CYC   ((`CSFS_SHIFT_HALF_NS * `CSFS_CLK_MHZ) / 1000)
`define CSFS_DONE_WAIT_SHIFTS 64
`define CSFS_FAIL_PULSE_NS    2000
`define CSFS_FAIL_PULSE_CYC   ((`CSFS_FAIL_PULSE_NS * `CSFS_CLK_MHZ + 999) / 1000)
`define CSFS_DONE_DATA        8'hff
`define CSFS_WAIT_DATA        8'h00

`endif

// file: rtl/csfs_pkg.sv
// Types shared by the configuration stream output unit
package csfs_pkg;

    typedef enum logic [2:0] {
        CSFS_SER1,
        CSFS_SER2,
        CSFS_SER4,
        CSFS_SER8,
        CSFS_BYTE_PAR
    } csfs_mode_type;

    typedef enum logic [2:0] {
        CSFS_ST_WAIT,
        CSFS_ST_SEND,
        CSFS_ST_CHECK,
        CSFS_ST_DONE,
        CSFS_ST_FAIL
    } csfs_state_type;

endpackage

// file: rtl/csfs_sync.sv
// Three-flop input synchroniser with agreement filter
`timescale 1ns/100ps

module csfs_sync #(
    parameter int           WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] level_nxt;

    // Accept a new level only once second and third stage agree
    always_comb begin
        level_nxt = level_out;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                level_nxt[i] = s3_r[i];
            end
        end
    end

    // First stage feeds only the second stage
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s1_r      <= RST_VAL;
            s2_r      <= RST_VAL;
            s3_r      <= RST_VAL;
            level_out <= RST_VAL;
        end else begin
            s1_r      <= async_in;
            s2_r      <= s1_r;
            s3_r      <= s2_r;
            level_out <= level_nxt;
        end
    end

endmodule // csfs_sync

// file: rtl/csfs_top.sv
// Configuration stream output and shared flash bus control
//
// What this block does
// - Byte parallel mode puts a whole byte on eight outputs per shift clock.
// - Any error on the shared status line halts and restarts the whole chain.
// - Only one configuration source per chain; no cascading of devices.
// - Single-bit serial shifts one bit on line zero, lines seven to one low until the last byte is out.
// - Concurrent serial drives n bits on the n lowest lines, n 1/2/4/8.
// - Mode width sets valid lines; lines above the width are driven low while streaming, high once the last byte is out.
// - Controller drives flash during config reads, programming and option read.
// - After completion the flash interface is released and the unit idles.
// - Status held low keeps the unit in reset, allowing external flash use.
// - Data changes so the FPGA latches it on the shift clock rising edge.
// - Start only with status high and done low; a status low pulse resets.
// - After completion the shift clock is held low and data driven high.
`timescale 1ns/100ps
`include "csfs_regs.svh"

module csfs_top
    import csfs_pkg::*;
#(
    parameter logic [7:0] HALF_CYC = 8'(`CSFS_SHIFT_HALF_CYC),
    parameter logic [7:0] FAIL_CYC = 8'(`CSFS_FAIL_PULSE_CYC)
) (
    input  wire logic          clk_in,
    input  wire logic          rst_n_in,
    input  wire csfs_mode_type mode_in,
    input  wire logic [7:0]    src_data_in,
    input  wire logic          src_valid_in,
    input  wire logic          src_last_in,
    input  wire logic          prog_active_in,
    input  wire logic          option_read_in,
    input  wire logic          status_in,
    input  wire logic          load_done_in,
    output logic               src_ready_out,
    output logic               config_shift_clock_out,
    output logic [7:0]         data_out,
    output logic               status_out,
    output logic               status_oe_out,
    output logic               flash_drive_out,
    output logic               idle_out
);

    generate
        // Fail pulse must last two cycles so its tail can be seen
        if (HALF_CYC < 8'h01 || FAIL_CYC < 8'h02) begin : g_bad_param
            $error("csfs_top: HALF_CYC must be at least one, FAIL_CYC at least two");
        end
    endgenerate

    localparam logic [6:0] DONE_WAIT = 7'(`CSFS_DONE_WAIT_SHIFTS);

    csfs_state_type st_r, st_nxt;
    csfs_mode_type  mode_r, mode_nxt;
    logic [7:0]     sh_r, sh_nxt;
    logic [7:0]     data_nxt;
    logic [2:0]     rem_r, rem_nxt;
    logic           have_r, have_nxt;
    logic           last_r, last_nxt;
    logic [7:0]     div_r, div_nxt;
    logic [6:0]     chk_r, chk_nxt;
    logic [7:0]     fail_r, fail_nxt;
    logic           clk_nxt;
    logic           ready_nxt;
    logic           oe_nxt;
    logic           flash_nxt;
    logic           idle_nxt;
    logic           status_s;
    logic           done_s;
    logic           take;
    logic           tick;

    // Status and load-complete come from other chips
    csfs_sync #(
        .WIDTH   (2),
        .RST_VAL (2'h0)
    ) u_sync (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .async_in  ({status_in, load_done_in}),
        .level_out ({status_s, done_s})
    );

    // Bits shifted per shift clock cycle
    function automatic logic [3:0] step_of(csfs_mode_type m);
        unique case (m)
            CSFS_SER1: step_of = 4'h1;
            CSFS_SER2: step_of = 4'h2;
            CSFS_SER4: step_of = 4'h4;
            default:   step_of = 4'h8;
        endcase
    endfunction

    // Shift clock cycles left in a byte after the first
    function automatic logic [2:0] rem_of(csfs_mode_type m);
        unique case (m)
            CSFS_SER1: rem_of = 3'h7;
            CSFS_SER2: rem_of = 3'h3;
            CSFS_SER4: rem_of = 3'h1;
            default:   rem_of = 3'h0;
        endcase
    endfunction

    // Top bits of the byte go out first; unused lines low
    function automatic logic [7:0] chunk_of(csfs_mode_type m, logic [7:0] b);
        unique case (m)
            CSFS_SER1: chunk_of = {7'h00, b[7]};
            CSFS_SER2: chunk_of = {6'h00, b[7:6]};
            CSFS_SER4: chunk_of = {4'h0, b[7:4]};
            default:   chunk_of = b;
        endcase
    endfunction

    assign take = src_ready_out && src_valid_in;
    assign tick = (div_r == 8'h00);

    // Sequencer: wait, stream, confirm, finish or fail
    always_comb begin
        st_nxt   = st_r;
        mode_nxt = mode_r;
        sh_nxt   = sh_r;
        data_nxt = data_out;
        rem_nxt  = rem_r;
        have_nxt = have_r;
        last_nxt = last_r;
        div_nxt  = tick ? HALF_CYC - 8'h01 : div_r - 8'h01;
        chk_nxt  = chk_r;
        fail_nxt = fail_r;
        clk_nxt  = config_shift_clock_out;
        unique case (st_r)
            CSFS_ST_WAIT: begin
                clk_nxt  = 1'b0;
                data_nxt = `CSFS_WAIT_DATA;
                have_nxt = 1'b0;
                rem_nxt  = 3'h0;
                last_nxt = 1'b0;
                div_nxt  = HALF_CYC - 8'h01;
                if (status_s && !done_s) begin
                    st_nxt   = CSFS_ST_SEND;
                    mode_nxt = mode_in;
                end
            end
            CSFS_ST_SEND: begin
                // Falling edge: next chunk appears while clock is low
                if (tick && config_shift_clock_out) begin
                    clk_nxt  = 1'b0;
                    have_nxt = 1'b0;
                    if (rem_r != 3'h0) begin
                        sh_nxt   = sh_r << step_of(mode_r);
                        data_nxt = chunk_of(mode_r, sh_r << step_of(mode_r));
                        rem_nxt  = rem_r - 3'h1;
                        have_nxt = 1'b1;
                    end else if (last_r) begin
                        st_nxt   = CSFS_ST_CHECK;
                        data_nxt = `CSFS_DONE_DATA;
                        chk_nxt  = 7'h00;
                    end
                end else if (tick && have_r) begin
                    clk_nxt = 1'b1;
                end
                // Empty source simply pauses the shift clock low
                if (take) begin
                    sh_nxt   = src_data_in;
                    data_nxt = chunk_of(mode_r, src_data_in);
                    rem_nxt  = rem_of(mode_r);
                    have_nxt = 1'b1;
                    last_nxt = src_last_in;
                end
            end
            CSFS_ST_CHECK: begin
                if (tick) begin
                    clk_nxt = !config_shift_clock_out;
                    if (config_shift_clock_out) begin
                        chk_nxt = chk_r + 7'h01;
                    end
                end
                if (done_s) begin
                    st_nxt  = CSFS_ST_DONE;
                    clk_nxt = 1'b0;
                end else if (chk_r == DONE_WAIT) begin
                    st_nxt   = CSFS_ST_FAIL;
                    fail_nxt = FAIL_CYC - 8'h01;
                    clk_nxt  = 1'b0;
                end
            end
            CSFS_ST_DONE: begin
                clk_nxt  = 1'b0;
                data_nxt = `CSFS_DONE_DATA;
            end
            CSFS_ST_FAIL: begin
                clk_nxt = 1'b0;
                if (fail_r == 8'h00) begin
                    st_nxt = CSFS_ST_WAIT;
                end else begin
                    fail_nxt = fail_r - 8'h01;
                end
            end
            default: begin
                st_nxt = CSFS_ST_WAIT;
            end
        endcase
        // Status low from anyone else resets the sequence; own pulse is timed out
        if (!status_s && st_r != CSFS_ST_FAIL && st_nxt != CSFS_ST_FAIL) begin
            st_nxt = CSFS_ST_WAIT;
        end
    end

    // Pin-side outputs derived from the next state
    always_comb begin
        ready_nxt = (st_nxt == CSFS_ST_SEND) && !have_nxt && (rem_nxt == 3'h0) &&
                    !last_nxt && !clk_nxt && !take;
        oe_nxt    = (st_nxt == CSFS_ST_FAIL);
        // Single owner of the flash bus, nothing to arbitrate
        flash_nxt = (st_nxt == CSFS_ST_SEND) || (st_nxt == CSFS_ST_CHECK) ||
                    prog_active_in || option_read_in;
        idle_nxt  = (st_nxt == CSFS_ST_DONE) && !flash_nxt;
    end

    // Register all state and outputs
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_r                   <= CSFS_ST_WAIT;
            mode_r                 <= CSFS_SER1;
            sh_r                   <= 8'h00;
            rem_r                  <= 3'h0;
            have_r                 <= 1'b0;
            last_r                 <= 1'b0;
            div_r                  <= 8'h00;
            chk_r                  <= 7'h00;
            fail_r                 <= 8'h00;
            config_shift_clock_out <= 1'b0;
            data_out               <= 8'h00;
            src_ready_out          <= 1'b0;
            status_out             <= 1'b0;
            status_oe_out          <= 1'b0;
            flash_drive_out        <= 1'b0;
            idle_out               <= 1'b0;
        end else begin
            st_r                   <= st_nxt;
            mode_r                 <= mode_nxt;
            sh_r                   <= sh_nxt;
            rem_r                  <= rem_nxt;
            have_r                 <= have_nxt;
            last_r                 <= last_nxt;
            div_r                  <= div_nxt;
            chk_r                  <= chk_nxt;
            fail_r                 <= fail_nxt;
            config_shift_clock_out <= clk_nxt;
            data_out               <= data_nxt;
            src_ready_out          <= ready_nxt;
            status_out             <= 1'b0; // Open drain, only ever pulls low
            status_oe_out          <= oe_nxt;
            flash_drive_out        <= flash_nxt;
            idle_out               <= idle_nxt;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    a_byte_load: assert property (
        (st_r == CSFS_ST_SEND && mode_r == CSFS_BYTE_PAR && take)
        |=> data_out == $past(src_data_in))
        else $error("byte mode did not present the taken byte");
    a_ser1_upper_low: assert property (
        (st_r == CSFS_ST_SEND && mode_r == CSFS_SER1) |-> data_out[7:1] == 7'h00)
        else $error("serial mode drove upper lines");
    a_ser1_first_bit: assert property (
        (st_r == CSFS_ST_SEND && mode_r == CSFS_SER1 && take)
        |=> data_out[0] == $past(src_data_in[7]))
        else $error("serial mode did not start with the top bit");
    a_width_mask: assert property (
        (st_r == CSFS_ST_SEND && mode_r == CSFS_SER2 && $past(st_r) == CSFS_ST_SEND)
        |-> data_out[7:2] == 6'h00)
        else $error("two-line mode drove unused lines");
    a_width4_mask: assert property (
        (st_r == CSFS_ST_SEND && mode_r == CSFS_SER4 && $past(st_r) == CSFS_ST_SEND)
        |-> data_out[7:4] == 4'h0)
        else $error("four-line mode drove unused lines");
    a_data_on_low: assert property (
        $changed(data_out) |-> !config_shift_clock_out)
        else $error("data changed while shift clock high");
    a_done_levels: assert property (
        (st_r == CSFS_ST_DONE) |=> (!config_shift_clock_out && data_out == 8'hff))
        else $error("done state not showing clock low and data high");
    a_done_release: assert property (
        (st_r == CSFS_ST_DONE && !prog_active_in && !option_read_in)
        |=> !flash_drive_out)
        else $error("flash interface not released after completion");
    a_flash_owned: assert property (
        (prog_active_in || option_read_in) |=> flash_drive_out)
        else $error("flash not driven during programming or option read");
    a_mode_held: assert property (
        (st_r != CSFS_ST_WAIT && $past(st_r) != CSFS_ST_WAIT) |-> $stable(mode_r))
        else $error("mode changed during a cycle");
    a_status_reset: assert property (
        (!status_s && st_r == CSFS_ST_SEND) |=> st_r == CSFS_ST_WAIT)
        else $error("status low did not reset the sequence");
    a_fail_pulse: assert property (
        (st_r == CSFS_ST_CHECK && !done_s && chk_r == DONE_WAIT)
        |=> (st_r == CSFS_ST_FAIL) ##1 status_oe_out)
        else $error("missing status low pulse after done timeout");

endmodule // csfs_top

// file: bench/csfs_fpga_model.sv
// Behavioural FPGA chain on the far side of the shift clock and data lines
`timescale 1ns/100ps

module csfs_fpga_model (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        shift_clk_in,
    input  wire logic        status_oe_in,
    input  wire logic        flash_drive_in,
    input  wire logic        hold_low_in,
    input  wire logic [15:0] target_in,
    output logic             status_wire_out,
    output logic             load_done_out,
    output logic             ext_flash_oe_out
);
    logic [15:0] rises_r;
    logic        sc_q;

    // Pulled-up wire; either side pulling low wins
    assign status_wire_out = ~(status_oe_in | hold_low_in);
    // Outsider touches flash only while held off and bus released
    assign ext_flash_oe_out = hold_low_in & ~flash_drive_in;

    // Count latched units; the whole chain reports done at once
    always @(posedge clk_in) begin
        sc_q <= shift_clk_in;
        if (!rst_n_in || !status_wire_out) begin
            rises_r <= 16'h0000;
            load_done_out <= 1'b0;
        end else begin
            if (shift_clk_in && !sc_q) begin
                rises_r <= rises_r + 16'h0001;
            end
            load_done_out <= (rises_r >= target_in);
        end
    end
endmodule // csfs_fpga_model

// file: bench/tb_top.sv
// Self-checking bench for the configuration stream output unit
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin miscompares++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end

module tb_top
    import csfs_pkg::*;
;
    logic          clk_in = 1'b0;
    logic          rst_n_in = 1'b0;
    csfs_mode_type mode_in = CSFS_SER1;
    logic [7:0]    src_data_in = 8'h00;
    logic          src_valid_in = 1'b0;
    logic          src_last_in = 1'b0;
    logic          prog_active_in = 1'b0;
    logic          option_read_in = 1'b0;
    logic          hold_low = 1'b0;
    logic [15:0]   target = 16'hffff;
    logic          status_w, done_w, ready_w, sclk_w, st_w, st_oe_w, flash_w, idle_w, ext_oe_w;
    logic [7:0]    data_w;
    logic [7:0]    exp_q[$];
    logic [7:0]    ex_c, seen;
    logic [31:0]   rnd = 32'h8395;
    logic          sc_q = 1'b0;
    logic          mon_en = 1'b1;
    int            miscompares = 0;
    int            num_checks = 0;

    csfs_top #(.HALF_CYC(8'h02), .FAIL_CYC(8'h04)) u_csfs_top (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .mode_in(mode_in),
        .src_data_in(src_data_in), .src_valid_in(src_valid_in), .src_last_in(src_last_in),
        .prog_active_in(prog_active_in), .option_read_in(option_read_in),
        .status_in(status_w), .load_done_in(done_w), .src_ready_out(ready_w),
        .config_shift_clock_out(sclk_w), .data_out(data_w), .status_out(st_w),
        .status_oe_out(st_oe_w), .flash_drive_out(flash_w), .idle_out(idle_w));

    csfs_fpga_model u_csfs_fpga_model (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .shift_clk_in(sclk_w),
        .status_oe_in(st_oe_w), .flash_drive_in(flash_w), .hold_low_in(hold_low),
        .target_in(target), .status_wire_out(status_w), .load_done_out(done_w),
        .ext_flash_oe_out(ext_oe_w));

    // 100 MHz system clock
    initial begin
        forever #5 clk_in = ~clk_in;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic sig_of(input int w);
        case (w)
            0: return idle_w;
            1: return st_oe_w;
            default: return ready_w;
        endcase
    endfunction

    task automatic end_sim();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Bounded wait on one design output
    task automatic wait_on(input int w, input int lim);
        int k;
        k = 0;
        // Look only between edges, never in the launching time step
        @(negedge clk_in);
        while (sig_of(w) !== 1'b1 && k < lim) begin
            @(negedge clk_in);
            k++;
        end
        `CHK("wait", 1'b1, sig_of(w))
    endtask

    task automatic do_reset(input csfs_mode_type m, input logic [15:0] tgt);
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        mode_in <= m;
        target <= tgt;
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
    endtask

    // Note the chunks of a byte, top bits first, then offer it until taken
    task automatic send(input logic [7:0] b, input logic last, input int n);
        int k;
        logic [7:0] t;
        for (k = 0; k < 8 / n; k++) begin
            t = b << (n * k);
            exp_q.push_back(t >> (8 - n));
        end
        rnd = lfsr(rnd);
        repeat (rnd[9:8]) @(posedge clk_in);
        @(posedge clk_in);
        src_data_in <= b;
        src_last_in <= last;
        src_valid_in <= 1'b1;
        k = 0;
        do begin
            @(negedge clk_in);
            k++;
        end while (ready_w !== 1'b1 && k < 2000);
        @(posedge clk_in);
        src_valid_in <= 1'b0;
    endtask

    // At each shift clock rise, compare what the FPGA latches
    always @(negedge clk_in) begin
        if (mon_en && sclk_w === 1'b1 && sc_q === 1'b0) begin
            seen = data_w;
            if (exp_q.size() > 0) begin
                ex_c = exp_q.pop_front();
                `CHK("chunk", ex_c, data_w)
            end else begin
                `CHK("tail", 8'hff, data_w)
            end
            `CHK("flash_busy", 1'b1, flash_w)
        end else if (mon_en && sclk_w === 1'b1) begin
            `CHK("hold", seen, data_w)
        end
        sc_q <= sclk_w;
    end

    // Run is cut short if any wait hangs
    initial begin
        #300000;
        miscompares++;
        end_sim();
    end

    initial begin
        int m, i, n;
        // Every mode, with the mode input moved mid-stream
        for (m = 0; m < 5; m++) begin
            n = (m == 4) ? 8 : (1 << m);
            do_reset(csfs_mode_type'(m), 16'(3 * 8 / n));
            for (i = 0; i < 3; i++) begin
                rnd = lfsr(rnd);
                send(rnd[7:0], i == 2, n);
                if (i == 0) mode_in <= csfs_mode_type'((m + 2) % 5);
            end
            wait_on(0, 3000);
            `CHK("done_data", 8'hff, data_w)
            `CHK("done_clk", 1'b0, sclk_w)
            `CHK("released", 1'b0, flash_w)
            `CHK("drained", 0, exp_q.size())
        end
        // Programming and option read take the bus while idle
        for (i = 0; i < 2; i++) begin
            @(posedge clk_in);
            prog_active_in <= (i == 0);
            option_read_in <= (i == 1);
            repeat (3) @(negedge clk_in);
            `CHK("flash_own", 1'b1, flash_w)
            `CHK("busy_idle", 1'b0, idle_w)
            @(posedge clk_in);
            prog_active_in <= 1'b0;
            option_read_in <= 1'b0;
            repeat (3) @(negedge clk_in);
            `CHK("flash_free", 1'b0, flash_w)
            `CHK("idle_again", 1'b1, idle_w)
        end
        // Outsider holds status low mid-stream, then lets go
        do_reset(CSFS_SER4, 16'h0004);
        send(8'h5a, 1'b0, 4);
        mon_en = 1'b0;
        @(posedge clk_in);
        hold_low <= 1'b1;
        repeat (20) @(negedge clk_in);
        `CHK("held_data", 8'h00, data_w)
        `CHK("held_clk", 1'b0, sclk_w)
        `CHK("held_ready", 1'b0, ready_w)
        `CHK("held_flash", 1'b0, flash_w)
        `CHK("ext_access", 1'b1, ext_oe_w)
        exp_q.delete();
        @(posedge clk_in);
        hold_low <= 1'b0;
        wait_on(2, 100);
        mon_en = 1'b1;
        send(8'hc3, 1'b0, 4);
        send(8'h3c, 1'b1, 4);
        wait_on(0, 3000);
        // No load-complete: timeout pulls status low for the pulse length
        do_reset(CSFS_SER8, 16'hffff);
        send(8'ha5, 1'b1, 8);
        wait_on(1, 1000);
        i = 0;
        while (st_oe_w === 1'b1 && i < 50) begin
            @(negedge clk_in);
            i++;
        end
        `CHK("pulse_len", 4, i)
        // Lines fall to the waiting value one cycle after the pulse ends
        @(negedge clk_in);
        `CHK("fail_data", 8'h00, data_w)
        `CHK("fail_level", 1'b0, st_w)
        end_sim();
    end
endmodule // tb_top
